// file: hdl/spi_pkg.sv
// Constants, types and field layout of the serial port block
package spi_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h10;
    localparam logic [5:0] IDX_STAT = 6'h11;
    localparam logic [5:0] IDX_DATA = 6'h12;
    // Control register fields
    localparam int B_EN    = 0;
    localparam int B_MST   = 1;
    localparam int B_CLOCK_POLARITY_SELECT  = 2;
    localparam int B_CLOCK_PHASE_SELECT  = 3;
    // Status and control register fields
    localparam int B_RS0   = 0;
    localparam int B_RS1   = 1;
    localparam int B_MFEN  = 2;
    localparam int B_ERROR_INTERRUPT_ENABLE = 3;
    localparam int B_MODE_FAULT_FLAG  = 4;
    localparam int B_OVERFLOW_FLAG  = 5;
    localparam int B_RXF   = 7;
    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    // Half-bit masks of the free-running divider (div 2, 8, 32, 128)
    localparam logic [5:0] HALF_DIV2   = 6'h00;
    localparam logic [5:0] HALF_DIV8   = 6'h03;
    localparam logic [5:0] HALF_DIV32  = 6'h0f;
    localparam logic [5:0] HALF_DIV128 = 6'h3f;
    // Edge and bit counts of one byte
    localparam logic [3:0] LAST_HALF = 4'hf;
    localparam logic [3:0] LAST_BIT  = 4'h7;
    localparam logic [3:0] ALL_BITS  = 4'h8;
    typedef enum logic [0:0] {ST_IDLE = 1'b0, ST_BUSY = 1'b1} xfer_state_t;
endpackage : spi_pkg

// file: hdl/spi_format_and_overflow_logic.sv
// Serial port core: formats, master timing, overflow and mode fault
`timescale 1ns/1ns
module spi_format_and_overflow_logic
    import spi_pkg::*;
#(
    parameter int ADR_W = 8
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_srst,
    // Wishbone slave
    input  wire logic             i_wb_cyc,
    input  wire logic             i_wb_stb,
    input  wire logic             i_wb_we,
    input  wire logic [ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]       i_wb_sel,
    input  wire logic [31:0]      i_wb_dat,
    output logic      [31:0]      o_wb_dat,
    output logic                  o_wb_ack,
    // Serial clock pin
    input  wire logic             i_sclk,
    output logic                  o_sclk,
    output logic                  o_sclk_oe_n,
    // Master-out data pin
    input  wire logic             i_mosi,
    output logic                  o_mosi,
    output logic                  o_mosi_oe_n,
    // Master-in data pin
    input  wire logic             i_miso,
    output logic                  o_miso,
    output logic                  o_miso_oe_n,
    // Slave select pin
    input  wire logic             i_ss_n,
    // Error request (overflow or mode fault)
    output logic                  o_error_irq
);
    // Pin synchronisers: sclk, mosi, miso, ss_n
    logic [3:0] meta_q;
    logic [3:0] sync_q;
    logic       sck_s, mosi_s, miso_s, ss_n_s;

    // Register and core state
    logic [7:0]  ctrl_q, ctrl_d;
    logic [1:0]  rate_q, rate_d;
    logic        mfen_q, mfen_d, error_interrupt_enable_q, error_interrupt_enable_d;
    logic        mode_fault_flag_q, mode_fault_flag_d, overflow_flag_q, overflow_flag_d, rxf_q, rxf_d;
    logic        arm_rf_q, arm_rf_d, arm_ov_q, arm_ov_d;
    logic        arm_mf_q, arm_mf_d;
    logic [7:0]  rxd_q, rxd_d, txd_q, txd_d;
    logic [7:0]  tsh_q, tsh_d, rsh_q, rsh_d;
    logic        pend_q, pend_d;
    xfer_state_t st_q, st_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [5:0]  lag_q, lag_d;      // Master strobes, two stages
    logic [5:0]  div_q, div_d;
    logic        sck_q, sck_d, dout_q, dout_d;
    logic        sck_prev_q, sck_prev_d, ss_prev_q, ss_prev_d;
    logic        ack_q, ack_d, irq_q, irq_d;
    logic [31:0] rdat_q, rdat_d;
    logic        sclk_oe_n_q, sclk_oe_n_d, miso_oe_n_q, miso_oe_n_d;

    // Decode and event terms
    logic       en, mst, clock_polarity_select, clock_phase_select, acc, wr, rd;
    logic       hit_c, hit_s, hit_d, tick, fault;
    logic       lead, trail, smp, shf, done, first, din;
    logic [5:0] mask;

    assign sck_s  = sync_q[0];
    assign mosi_s = sync_q[1];
    assign miso_s = sync_q[2];
    assign ss_n_s = sync_q[3];

    // First stage feeds only the second stage
    always_ff @(posedge i_ref_clk) begin
        meta_q <= {i_ss_n, i_miso, i_mosi, i_sclk};
        sync_q <= meta_q;
    end

    // Next-state logic of bus slave, flags and shifter
    always_comb begin
        en    = ctrl_q[B_EN];
        mst   = ctrl_q[B_MST];
        clock_polarity_select  = ctrl_q[B_CLOCK_POLARITY_SELECT];
        clock_phase_select  = ctrl_q[B_CLOCK_PHASE_SELECT];
        acc   = i_wb_cyc & i_wb_stb & ~ack_q;
        wr    = acc & i_wb_we & i_wb_sel[0];
        rd    = acc & ~i_wb_we;
        hit_c = i_wb_adr == ADR_W'({IDX_CTRL, 2'b00});
        hit_s = i_wb_adr == ADR_W'({IDX_STAT, 2'b00});
        hit_d = i_wb_adr == ADR_W'({IDX_DATA, 2'b00});
        unique case ({rate_q[1], rate_q[0]})
            2'b00:   mask = HALF_DIV2;
            2'b01:   mask = HALF_DIV8;
            2'b10:   mask = HALF_DIV32;
            2'b11:   mask = HALF_DIV128;
        endcase
        ctrl_d      = ctrl_q;
        rate_d      = rate_q;
        mfen_d      = mfen_q;
        error_interrupt_enable_d     = error_interrupt_enable_q;
        mode_fault_flag_d      = mode_fault_flag_q;
        overflow_flag_d      = overflow_flag_q;
        rxf_d       = rxf_q;
        arm_rf_d    = arm_rf_q;
        arm_ov_d    = arm_ov_q;
        arm_mf_d    = arm_mf_q;
        rxd_d       = rxd_q;
        txd_d       = txd_q;
        tsh_d       = tsh_q;
        rsh_d       = rsh_q;
        pend_d      = pend_q;
        st_d        = st_q;
        cnt_d       = cnt_q;
        sck_d       = sck_q;
        dout_d      = dout_q;
        sck_prev_d  = sck_s;
        ss_prev_d   = ss_n_s;
        ack_d       = acc;
        rdat_d      = 32'h0000_0000;
        smp         = 1'b0;
        shf         = 1'b0;
        done        = 1'b0;
        first       = 1'b0;
        din         = mst ? miso_s : mosi_s;
        // free-running divider
        // Runs only while enabled as master to save power
        div_d = (en & mst) ? div_q + 6'h01 : 6'h00;
        tick  = en & mst & ((div_q & mask) == mask);
        lead  = en & ~mst & ~ss_n_s & (sck_s != sck_prev_q) & (sck_s != clock_polarity_select);
        trail = en & ~mst & ~ss_n_s & (sck_s != sck_prev_q) & (sck_s == clock_polarity_select);
        fault = mst ? (en & ~ss_n_s)
                    : (st_q == ST_BUSY & ss_n_s);

        // Register reads; unmapped reads answer zero
        if (rd & hit_c) begin
            rdat_d[7:0] = ctrl_q;
        end
        if (rd & hit_s) begin
            rdat_d[B_RXF]   = rxf_q;
            rdat_d[B_OVERFLOW_FLAG]  = overflow_flag_q;
            rdat_d[B_MODE_FAULT_FLAG]  = mode_fault_flag_q;
            rdat_d[B_ERROR_INTERRUPT_ENABLE] = error_interrupt_enable_q;
            rdat_d[B_MFEN]  = mfen_q;
            rdat_d[B_RS1]   = rate_q[1];
            rdat_d[B_RS0]   = rate_q[0];
            // Flags seen now may be cleared by the next access
            arm_rf_d = rxf_q;
            arm_ov_d = overflow_flag_q;
            arm_mf_d = mode_fault_flag_q;
        end
        if (rd & hit_d) begin
            rdat_d[7:0] = rxd_q;
            if (arm_rf_q) begin
                rxf_d = 1'b0;
            end
            if (arm_ov_q) begin
                overflow_flag_d = 1'b0;
            end
            arm_rf_d = 1'b0;
            arm_ov_d = 1'b0;
        end

        // Register writes
        if (wr & hit_c) begin
            ctrl_d = {4'h0, i_wb_dat[3:0]};
            // Fault clears only with no fault condition present
            if (arm_mf_q & ~fault) begin
                mode_fault_flag_d = 1'b0;
            end
            arm_mf_d = 1'b0;
        end
        if (wr & hit_s) begin
            rate_d  = {i_wb_dat[B_RS1], i_wb_dat[B_RS0]};
            mfen_d  = i_wb_dat[B_MFEN];
            error_interrupt_enable_d = i_wb_dat[B_ERROR_INTERRUPT_ENABLE];
        end
        if (wr & hit_d) begin
            txd_d = i_wb_dat[7:0];
            // only a data write starts master
            pend_d = en & mst;
        end

        // Transfer sequencing
        unique case (st_q)
            ST_IDLE: begin
                cnt_d = 4'h0;
                if (mst) begin
                    // edges launched from the bus clock flop
                    sck_d = clock_polarity_select;
                    if (pend_q & tick) begin
                        st_d   = ST_BUSY;
                        pend_d = 1'b0;
                        // phase 0 waits a half bit
                        tsh_d  = clock_phase_select ? txd_q : {txd_q[6:0], 1'b0};
                        dout_d = clock_phase_select ? dout_q : txd_q[7];
                    end
                end else if (en & ~clock_phase_select & ss_prev_q & ~ss_n_s) begin
                    st_d   = ST_BUSY;
                    tsh_d  = {txd_q[6:0], 1'b0};
                    dout_d = txd_q[7];
                end else if (clock_phase_select & lead) begin
                    st_d   = ST_BUSY;
                    tsh_d  = txd_q;
                    shf    = 1'b1;
                end
            end
            ST_BUSY: begin
                if (mst & tick) begin
                    sck_d = ~sck_q;
                    cnt_d = cnt_q + 4'h1;
                    first = cnt_q[3:1] == 3'h0;
                    // phase 1 leads with active edge
                    smp  = clock_phase_select ? cnt_q[0] : ~cnt_q[0];
                    shf  = clock_phase_select ? ~cnt_q[0]
                                : (cnt_q[0] & cnt_q != LAST_HALF);
                    done = cnt_q == LAST_HALF;
                end else if (~mst & ~clock_phase_select) begin
                    first = cnt_q == 4'h0;
                    smp   = lead;
                    shf   = trail & cnt_q != ALL_BITS;
                    done  = trail & cnt_q == ALL_BITS;
                end else if (~mst) begin
                    // select may stay low between bytes
                    first = cnt_q == 4'h0;
                    shf   = lead;
                    smp   = trail;
                    done  = trail & cnt_q == LAST_BIT;
                end
                if (~mst & smp) begin
                    cnt_d = cnt_q + 4'h1;
                end
                if (done) begin
                    st_d = ST_IDLE;
                end
                if (~mst & ss_n_s) begin
                    st_d = ST_IDLE;
                end
            end
        endcase

        // Returning line lags two cycles behind the synchroniser,
        // so the master's sample, first and store strobes trail too
        lag_d = {lag_q[2:0], mst & smp, mst & first, mst & done};
        if (mst) begin
            smp   = lag_q[5];
            first = lag_q[4];
            done  = lag_q[3];
        end

        if (shf) begin
            dout_d = tsh_d[7];
            tsh_d  = {tsh_d[6:0], 1'b0};
        end
        if (smp) begin
            rsh_d = {rsh_q[6:0], din};
        end
        if (smp & first & rxf_q) begin
            overflow_flag_d = 1'b1;
        end
        if (done & ~overflow_flag_d & ~rxf_d) begin
            rxd_d = rsh_d;
            rxf_d = 1'b1;
        end
        if (fault & mfen_q) begin
            mode_fault_flag_d = 1'b1;
        end

        // Disabled port aborts and idles the clock
        if (~en) begin
            st_d   = ST_IDLE;
            pend_d = 1'b0;
            sck_d  = clock_polarity_select;
            lag_d  = 6'h00;
        end
        irq_d       = error_interrupt_enable_q & (overflow_flag_d | mode_fault_flag_d);
        sclk_oe_n_d = ~(en & mst);
        miso_oe_n_d = ~(en & ~mst & ~ss_n_s);
    end

    // State registers
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            ctrl_q      <= CTRL_RST;
            rate_q      <= STAT_RST[1:0];
            mfen_q      <= STAT_RST[B_MFEN];
            error_interrupt_enable_q     <= STAT_RST[B_ERROR_INTERRUPT_ENABLE];
            mode_fault_flag_q      <= STAT_RST[B_MODE_FAULT_FLAG];
            overflow_flag_q      <= STAT_RST[B_OVERFLOW_FLAG];
            rxf_q       <= STAT_RST[B_RXF];
            arm_rf_q    <= 1'b0;
            arm_ov_q    <= 1'b0;
            arm_mf_q    <= 1'b0;
            rxd_q       <= 8'h00;
            txd_q       <= 8'h00;
            tsh_q       <= 8'h00;
            rsh_q       <= 8'h00;
            pend_q      <= 1'b0;
            st_q        <= ST_IDLE;
            cnt_q       <= 4'h0;
            lag_q       <= 6'h00;
            div_q       <= 6'h00;
            sck_q       <= 1'b0;
            dout_q      <= 1'b0;
            sck_prev_q  <= 1'b0;
            ss_prev_q   <= 1'b1;
            ack_q       <= 1'b0;
            irq_q       <= 1'b0;
            rdat_q      <= 32'h0000_0000;
            sclk_oe_n_q <= 1'b1;
            miso_oe_n_q <= 1'b1;
        end else begin
            ctrl_q      <= ctrl_d;
            rate_q      <= rate_d;
            mfen_q      <= mfen_d;
            error_interrupt_enable_q     <= error_interrupt_enable_d;
            mode_fault_flag_q      <= mode_fault_flag_d;
            overflow_flag_q      <= overflow_flag_d;
            rxf_q       <= rxf_d;
            arm_rf_q    <= arm_rf_d;
            arm_ov_q    <= arm_ov_d;
            arm_mf_q    <= arm_mf_d;
            rxd_q       <= rxd_d;
            txd_q       <= txd_d;
            tsh_q       <= tsh_d;
            rsh_q       <= rsh_d;
            pend_q      <= pend_d;
            st_q        <= st_d;
            cnt_q       <= cnt_d;
            lag_q       <= lag_d;
            div_q       <= div_d;
            sck_q       <= sck_d;
            dout_q      <= dout_d;
            sck_prev_q  <= sck_prev_d;
            ss_prev_q   <= ss_prev_d;
            ack_q       <= ack_d;
            irq_q       <= irq_d;
            rdat_q      <= rdat_d;
            sclk_oe_n_q <= sclk_oe_n_d;
            miso_oe_n_q <= miso_oe_n_d;
        end
    end

    // Outputs straight from flops; one data flop serves both lines
    assign o_wb_dat    = rdat_q;
    assign o_wb_ack    = ack_q;
    assign o_sclk      = sck_q;
    assign o_sclk_oe_n = sclk_oe_n_q;
    assign o_mosi      = dout_q;
    assign o_mosi_oe_n = sclk_oe_n_q;
    assign o_miso      = dout_q;
    assign o_miso_oe_n = miso_oe_n_q;
    assign o_error_irq = irq_q;
endmodule : spi_format_and_overflow_logic

// file: sim/spi_format_and_overflow_logic_props.sv
// Port checker for the serial port core
`timescale 1ns/1ns
module spi_format_and_overflow_logic_props #(
    parameter int ADR_W = 8
) (
    // Clock and reset
    input wire logic             i_ref_clk,
    input wire logic             i_srst,
    // Register bus
    input wire logic             i_wb_cyc,
    input wire logic             i_wb_stb,
    input wire logic             i_wb_we,
    input wire logic [ADR_W-1:0] i_wb_adr,
    input wire logic [3:0]       i_wb_sel,
    input wire logic [31:0]      i_wb_dat,
    input wire logic [31:0]      o_wb_dat,
    input wire logic             o_wb_ack,
    // Serial pins
    input wire logic             i_sclk,
    input wire logic             o_sclk,
    input wire logic             o_sclk_oe_n,
    input wire logic             i_mosi,
    input wire logic             o_mosi,
    input wire logic             o_mosi_oe_n,
    input wire logic             i_miso,
    input wire logic             o_miso,
    input wire logic             o_miso_oe_n,
    input wire logic             i_ss_n,
    // Error request
    input wire logic             o_error_irq
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    // Bus answers in exactly one cycle, as a single pulse
    property p_ack_taken; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
    a_ack_taken: assert property (p_ack_taken) else $error("ack missing");
    property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
    property p_dat_high; o_wb_ack |-> o_wb_dat[31:8] == 24'h0; endproperty
    a_dat_high: assert property (p_dat_high) else $error("upper bits set");
    // A master never drives the slave-out line
    property p_master_quiet; !o_sclk_oe_n |-> o_miso_oe_n; endproperty
    a_master_quiet: assert property (p_master_quiet)
        else $error("master drives miso");
    property p_ss_float; i_ss_n [*4] |=> o_miso_oe_n; endproperty
    a_ss_float: assert property (p_ss_float)
        else $error("deselected slave drives");
    property p_mosi_oe; o_mosi_oe_n == o_sclk_oe_n; endproperty
    a_mosi_oe: assert property (p_mosi_oe)
        else $error("mosi and clock enables differ");
    // Flags only clear through bus accesses
    property p_irq_fall;
        $fell(o_error_irq) |-> o_wb_ack || $past(o_wb_ack);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("request fell without access");
endmodule : spi_format_and_overflow_logic_props

// file: sim/spi_slave_model.sv
// Behavioural far-end slave for the serial port core
`timescale 1ns/1ns
module spi_slave_model (
    // Serial lines
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic       i_ss_n,
    // Mode and data
    input  wire logic       i_clock_polarity_select,
    input  wire logic       i_clock_phase_select,
    input  wire logic [7:0] i_tx,
    output logic            o_miso,
    output logic [7:0]      o_rx
);
    logic [7:0] sh = 8'h00;
    int         cnt = 0;
    initial o_miso = 1'b0;
    initial o_rx = 8'h00;
    // select fall loads, and in phase 0 shows the first bit
    always @(negedge i_ss_n) begin
        sh = i_tx;
        cnt = 0;
        if (!i_clock_phase_select)
            o_miso = i_tx[7];
    end
    // Released line shows the inverse, never a held value
    always @(posedge i_ss_n) o_miso = ~o_miso;
    // MSB first on leading and trailing edges
    always @(i_sclk) begin
        if (!i_ss_n && i_sclk != i_clock_polarity_select && i_clock_phase_select) begin
            if (cnt == 0)
                sh = i_tx;
            o_miso = sh[7];
            sh = sh << 1;
        end else if (!i_ss_n && i_sclk != i_clock_polarity_select) begin
            o_rx = {o_rx[6:0], i_mosi};
        end else if (!i_ss_n && i_clock_phase_select) begin
            o_rx = {o_rx[6:0], i_mosi};
            cnt = (cnt + 1) % 8;
        end else if (!i_ss_n) begin
            sh = sh << 1;
            o_miso = sh[7];
        end
    end
endmodule : spi_slave_model

// file: sim/spi_format_and_overflow_logic_test.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ns
module spi_format_and_overflow_logic_test;
    import spi_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat, rq;
    logic        ack, sck, sck_oe_n, mo, mo_oe_n, mi, mi_oe_n, irq, s_mi;
    logic        ss_n = 1'b1;
    logic        s_ss_n = 1'b1;
    logic        clock_polarity_select = 1'b0;
    logic        clock_phase_select = 1'b0;
    logic [7:0]  s_tx = 8'h00;
    logic [7:0]  s_rx;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    // Undriven clock line rests at the idle level
    wire sck_w = sck_oe_n ? clock_polarity_select : sck;
    wire mo_w  = mo_oe_n ? 1'b0 : mo;
    wire mi_w  = mi_oe_n ? s_mi : mi;
    spi_format_and_overflow_logic #(.ADR_W(8)) i_dut (
        .i_ref_clk(clk), .i_srst(srst), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_sclk(sck_w), .o_sclk(sck),
        .o_sclk_oe_n(sck_oe_n), .i_mosi(mo_w), .o_mosi(mo),
        .o_mosi_oe_n(mo_oe_n), .i_miso(mi_w), .o_miso(mi),
        .o_miso_oe_n(mi_oe_n), .i_ss_n(ss_n), .o_error_irq(irq)
    );
    spi_slave_model i_far (
        .i_sclk(sck_w), .i_mosi(mo_w), .i_ss_n(s_ss_n), .i_clock_polarity_select(clock_polarity_select),
        .i_clock_phase_select(clock_phase_select), .i_tx(s_tx), .o_miso(s_mi), .o_rx(s_rx)
    );
    always #25 clk = ~clk;
    // Hang guard, far above the longest expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One classic cycle; holds until ack, data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
        @(posedge clk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {24'h0, d};
        do
            @(posedge clk);
        while (ack !== 1'b1);
        rq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    // One master byte; counts clock edges and start delay
    task automatic xfer(input logic [7:0] tx, input logic [7:0] rx,
                        input int bit_t);
        int   n;
        int   c;
        int   lim;
        logic sp;
        s_tx   <= rx;
        s_ss_n <= 1'b0;
        wb(1'b1, 8'h48, tx);
        n = 0;
        c = 0;
        lim = 0;
        sp = sck;
        while (n < 16 && c < 4000) begin
            @(posedge clk);
            c++;
            if (sck !== sp && n == 0)
                lim = c;
            if (sck !== sp)
                n++;
            sp = sck;
        end
        chk(32'(lim <= bit_t + (clock_phase_select ? bit_t / 2 : 0) + 2), 32'h1);
        repeat (4) @(posedge clk);
        chk({31'h0, sck}, {31'h0, clock_polarity_select});
        chk({24'h0, s_rx}, {24'h0, tx});
        if (!clock_phase_select)
            s_ss_n <= 1'b1;
    endtask : xfer
    task automatic drain(input logic [7:0] exp);
        wb(1'b0, 8'h44, 8'h00);
        wb(1'b0, 8'h48, 8'h00);
        chk(rq, {24'h0, exp});
    endtask : drain
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        wb(1'b0, 8'h40, 8'h00);
        chk(rq, {24'h0, CTRL_RST});
        wb(1'b0, 8'h44, 8'h00);
        chk(rq, {24'h0, STAT_RST});
        wb(1'b1, 8'h4c, 8'hff);
        wb(1'b0, 8'h4c, 8'h00);
        chk(rq, 32'h0);
        // Enabled slave drives only while selected
        wb(1'b1, 8'h40, 8'h01);
        ss_n <= 1'b0;
        repeat (6) @(posedge clk);
        chk({31'h0, mi_oe_n}, 32'h0);
        ss_n <= 1'b1;
        repeat (6) @(posedge clk);
        chk({31'h0, mi_oe_n}, 32'h1);
        // Every mode, mode m at rate m, disabled around changes
        for (int m = 0; m < 4; m++) begin
            wb(1'b1, 8'h40, 8'h00);
            clock_polarity_select <= m[0];
            clock_phase_select <= m[1];
            wb(1'b1, 8'h40, {4'h0, m[1], m[0], 2'b00});
            wb(1'b1, 8'h44, {6'h0, m[1:0]});
            wb(1'b1, 8'h40, {4'h0, m[1], m[0], 2'b11});
            xfer(8'h5a ^ 8'(m), 8'hc3 ^ 8'(m), 2 << (2 * m));
            drain(8'hc3 ^ 8'(m));
            if (m == 3)
                xfer(8'h96, 8'h3c, 128);
            if (m == 3)
                drain(8'h3c);
            s_ss_n <= 1'b1;
        end
        // Overflow with the error request enabled
        wb(1'b1, 8'h40, 8'h00);
        clock_polarity_select <= 1'b0;
        clock_phase_select <= 1'b0;
        wb(1'b1, 8'h44, 8'h09);
        wb(1'b1, 8'h40, 8'h03);
        xfer(8'h11, 8'ha1, 8);
        wb(1'b0, 8'h44, 8'h00);
        chk(rq, 32'h89);
        xfer(8'h22, 8'ha2, 8);
        chk({31'h0, irq}, 32'h1);
        wb(1'b0, 8'h48, 8'h00);
        chk(rq, 32'ha1);
        wb(1'b0, 8'h44, 8'h00);
        chk(rq, 32'h29);
        xfer(8'h33, 8'ha3, 8);
        wb(1'b0, 8'h44, 8'h00);
        chk(rq, 32'h29);
        wb(1'b0, 8'h48, 8'h00);
        wb(1'b0, 8'h44, 8'h00);
        chk(rq, 32'h09);
        chk({31'h0, irq}, 32'h0);
        // Master selected from outside: fault only when checked
        ss_n <= 1'b0;
        repeat (6) @(posedge clk);
        wb(1'b0, 8'h44, 8'h00);
        chk(rq, 32'h09);
        wb(1'b1, 8'h44, 8'h0d);
        repeat (6) @(posedge clk);
        wb(1'b0, 8'h44, 8'h00);
        chk(rq, 32'h1d);
        chk({31'h0, irq}, 32'h1);
        ss_n <= 1'b1;
        repeat (6) @(posedge clk);
        wb(1'b0, 8'h44, 8'h00);
        wb(1'b1, 8'h40, 8'h00);
        wb(1'b0, 8'h44, 8'h00);
        chk(rq, 32'h0d);
        chk({31'h0, irq}, 32'h0);
        tally_and_finish();
    end
endmodule : spi_format_and_overflow_logic_test
bind spi_format_and_overflow_logic spi_format_and_overflow_logic_props
    #(.ADR_W(ADR_W)) i_props (.*);
